// *** hw/oqs_pkg.sv ***
// shared constants and types for the operation/questionable status block
package oqs_pkg;

  localparam int unsigned REG_W = 16;

  // operation group bit positions
  localparam int unsigned OPER_LIST_RUNNING_BIT = 14;
  localparam int unsigned OPER_LIST_DONE_BIT = 12;
  localparam int unsigned OPER_SAMPLE_DONE_BIT = 11;
  localparam int unsigned OPER_CC_MODE_BIT = 10;
  localparam int unsigned OPER_TRANSIENT_DONE_BIT = 9;
  localparam int unsigned OPER_CV_MODE_BIT = 8;
  localparam int unsigned OPER_TRANSIENT_ARMED_BIT = 6;
  localparam int unsigned OPER_WAIT_TRIG_BIT = 5;

  // questionable group bit positions
  localparam int unsigned QUES_ABSORBING_BIT = 14;
  localparam int unsigned QUES_CURRENT_ERR_BIT = 13;
  localparam int unsigned QUES_VOLTAGE_ERR_BIT = 12;
  localparam int unsigned QUES_SLAVE_ERR_BIT = 6;
  localparam int unsigned QUES_THERMAL_ERR_BIT = 3;
  localparam int unsigned QUES_CUR_MODE_ERR_BIT = 1;
  localparam int unsigned QUES_VOLT_MODE_ERR_BIT = 0;

  // bits that exist in each condition register
  localparam logic [15:0] OPER_USED_MASK = 16'h5F60;
  localparam logic [15:0] QUES_USED_MASK = 16'h704B;
  // bits that may latch into each event register
  localparam logic [15:0] OPER_LATCH_MASK = 16'h5F60;
  localparam logic [15:0] QUES_LATCH_MASK = 16'h3000;

  // enable mask values
  localparam logic [15:0] OPER_ENAB_RESET = 16'h0000;
  localparam logic [15:0] QUES_ENAB_RESET = 16'h0000;
  localparam logic [15:0] OPER_ENAB_PRESET = 16'h2001; // 8193
  localparam logic [15:0] QUES_ENAB_PRESET = 16'h00FF; // 255

  // status byte summary positions
  localparam int unsigned STB_OPER_SUMMARY_BIT = 7;
  localparam int unsigned STB_QUES_SUMMARY_BIT = 3;

  // status commands
  typedef enum logic [2:0] {
    CMD_OPER_COND_READ = 3'h0,
    CMD_OPER_ENAB_WRITE = 3'h1,
    CMD_OPER_ENAB_READ = 3'h2,
    CMD_OPER_EVENT_READ = 3'h3,
    CMD_STATUS_PRESET = 3'h4,
    CMD_QUES_EVENT_READ = 3'h5,
    CMD_QUES_COND_READ = 3'h6,
    CMD_QUES_ENAB_WRITE = 3'h7
  } oqs_cmd_type;

  typedef struct packed {
    oqs_cmd_type cmd;
    logic [15:0] wdata;
  } oqs_req_type;

  typedef struct packed {
    logic list_running;
    logic list_done;
    logic sample_done;
    logic constant_current_mode;
    logic transient_done;
    logic constant_voltage_mode;
    logic transient_armed;
    logic waiting_for_trigger;
  } oqs_oper_cond_type;

  typedef struct packed {
    logic absorbing_energy_flag;
    logic current_error_flag;
    logic voltage_error_flag;
    logic slave_error_flag;
    logic thermal_error_flag;
    logic current_mode_error;
    logic voltage_mode_error;
  } oqs_ques_cond_type;

endpackage

// *** hw/oqs_sync.sv ***
// two-flop synchroniser for a vector of level inputs
`timescale 1ns/100ps
module oqs_sync #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // oqs_sync

// *** hw/oqs_event_latch.sv ***
// rising-edge event latch with clear-on-read, set beats clear
`timescale 1ns/100ps
module oqs_event_latch #(
  parameter logic [15:0] LATCH_MASK = 16'hFFFF
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] cond,
  input wire logic clear,
  output logic [15:0] events
);

  logic [15:0] prev_q;
  logic [15:0] events_q;
  logic [15:0] events_d;
  logic [15:0] rise;

  // only permitted positions catch a rising condition
  assign rise = cond & ~prev_q & LATCH_MASK;

  // a read clears, but an edge in that same cycle survives
  assign events_d = (clear ? 16'h0000 : events_q) | rise;

  // previous condition sample for edge detection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 16'h0000;
    end else begin
      prev_q <= cond;
    end
  end

  // latched event bits
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      events_q <= 16'h0000;
    end else begin
      events_q <= events_d;
    end
  end

  assign events = events_q;

endmodule // oqs_event_latch

// *** hw/oqs_status_regs.sv ***
// operation and questionable status register groups with summary bits
`timescale 1ns/100ps

module oqs_status_regs (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire oqs_pkg::oqs_oper_cond_type oper_cond_in,
  input wire oqs_pkg::oqs_ques_cond_type ques_cond_in,
  input wire logic req_valid,
  input wire oqs_pkg::oqs_req_type req,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [7:0] status_byte_bits
);
  import oqs_pkg::*;

  logic [15:0] oper_raw;
  logic [15:0] ques_raw;
  logic [15:0] oper_live;
  logic [15:0] ques_live;
  logic [15:0] oper_events;
  logic [15:0] ques_events;
  logic [15:0] oper_enab_q;
  logic [15:0] ques_enab_q;
  logic oper_clear;
  logic ques_clear;
  logic rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic [15:0] rsp_data_d;
  logic [7:0] stb_q;
  logic [7:0] stb_d;

  // true when a request of the given command is taken this cycle
  function automatic logic cmd_hit(input logic valid,
                                   input oqs_cmd_type cmd,
                                   input oqs_cmd_type want);
    cmd_hit = valid && (cmd == want);
  endfunction

  // place operation condition inputs at their bit positions
  always_comb begin
    oper_raw = 16'h0000;
    oper_raw[OPER_LIST_RUNNING_BIT] = oper_cond_in.list_running;
    oper_raw[OPER_LIST_DONE_BIT] = oper_cond_in.list_done;
    oper_raw[OPER_SAMPLE_DONE_BIT] = oper_cond_in.sample_done;
    oper_raw[OPER_CC_MODE_BIT] = oper_cond_in.constant_current_mode;
    oper_raw[OPER_TRANSIENT_DONE_BIT] = oper_cond_in.transient_done;
    oper_raw[OPER_CV_MODE_BIT] = oper_cond_in.constant_voltage_mode;
    oper_raw[OPER_TRANSIENT_ARMED_BIT] = oper_cond_in.transient_armed;
    oper_raw[OPER_WAIT_TRIG_BIT] = oper_cond_in.waiting_for_trigger;
  end

  // place questionable condition inputs at their bit positions
  always_comb begin
    ques_raw = 16'h0000;
    ques_raw[QUES_ABSORBING_BIT] = ques_cond_in.absorbing_energy_flag;
    ques_raw[QUES_CURRENT_ERR_BIT] = ques_cond_in.current_error_flag;
    ques_raw[QUES_VOLTAGE_ERR_BIT] = ques_cond_in.voltage_error_flag;
    ques_raw[QUES_SLAVE_ERR_BIT] = ques_cond_in.slave_error_flag;
    ques_raw[QUES_THERMAL_ERR_BIT] = ques_cond_in.thermal_error_flag;
    // both mode bits may be high together while settling
    ques_raw[QUES_CUR_MODE_ERR_BIT] = ques_cond_in.current_mode_error;
    ques_raw[QUES_VOLT_MODE_ERR_BIT] = ques_cond_in.voltage_mode_error;
  end

  // condition pins come from the analog side, so synchronise them
  oqs_sync #(
    .WIDTH(REG_W)
  ) u_oper_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in(oper_raw),
    .sync_out(oper_live)
  );

  oqs_sync #(
    .WIDTH(REG_W)
  ) u_ques_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in(ques_raw),
    .sync_out(ques_live)
  );

  // read-to-clear strobes for the two event registers
  assign oper_clear = cmd_hit(req_valid, req.cmd,
                              CMD_OPER_EVENT_READ);
  assign ques_clear = cmd_hit(req_valid, req.cmd,
                              CMD_QUES_EVENT_READ);

  // operation events: every defined bit latches on its rising edge
  oqs_event_latch #(
    .LATCH_MASK(OPER_LATCH_MASK)
  ) u_oper_events (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cond(oper_live),
    .clear(oper_clear),
    .events(oper_events)
  );

  // questionable events: only current and voltage error latch;
  // past the synchroniser the mode error bits reach the edge-detect sample flop and the condition read data, never an event flop
  oqs_event_latch #(
    .LATCH_MASK(QUES_LATCH_MASK)
  ) u_ques_events (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cond(ques_live),
    .clear(ques_clear),
    .events(ques_events)
  );

  // operation enable mask: whole-word write, preset wins on its own cmd
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oper_enab_q <= OPER_ENAB_RESET;
    end else if (cmd_hit(req_valid, req.cmd, CMD_STATUS_PRESET)) begin
      oper_enab_q <= OPER_ENAB_PRESET;
    end else if (cmd_hit(req_valid, req.cmd, CMD_OPER_ENAB_WRITE)) begin
      oper_enab_q <= req.wdata;
    end
  end

  // questionable enable mask
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ques_enab_q <= QUES_ENAB_RESET;
    end else if (cmd_hit(req_valid, req.cmd, CMD_STATUS_PRESET)) begin
      ques_enab_q <= QUES_ENAB_PRESET;
    end else if (cmd_hit(req_valid, req.cmd, CMD_QUES_ENAB_WRITE)) begin
      ques_enab_q <= req.wdata;
    end
  end

  // read data mux; condition reads return the live value, unlatched
  always_comb begin
    rsp_data_d = 16'h0000;
    case (req.cmd)
      CMD_OPER_COND_READ: begin
        rsp_data_d = oper_live;
      end
      CMD_OPER_ENAB_READ: begin
        rsp_data_d = oper_enab_q;
      end
      CMD_OPER_EVENT_READ: begin
        rsp_data_d = oper_events;
      end
      CMD_QUES_EVENT_READ: begin
        rsp_data_d = ques_events;
      end
      CMD_QUES_COND_READ: begin
        rsp_data_d = ques_live;
      end
      default: begin
        rsp_data_d = 16'h0000; // writes and preset answer with zero
      end
    endcase
  end

  // every taken request is answered one cycle later
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
    end else begin
      rsp_valid_q <= req_valid;
      if (req_valid) begin
        rsp_data_q <= rsp_data_d;
      end
    end
  end

  // summary bits: a set mask bit enables its event
  always_comb begin
    stb_d = 8'h00;
    stb_d[STB_OPER_SUMMARY_BIT] = |(oper_events & oper_enab_q);
    stb_d[STB_QUES_SUMMARY_BIT] = |(ques_events & ques_enab_q);
  end

  // registered summary outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stb_q <= 8'h00;
    end else begin
      stb_q <= stb_d;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign status_byte_bits = stb_q;

endmodule // oqs_status_regs

// *** tb/oqs_status_regs_sva.sv ***
// port assertions for the status register block
`timescale 1ns/100ps
module oqs_status_regs_sva (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire oqs_pkg::oqs_oper_cond_type oper_cond_in,
  input wire oqs_pkg::oqs_ques_cond_type ques_cond_in,
  input wire logic req_valid,
  input wire oqs_pkg::oqs_req_type req,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0] status_byte_bits
);
  import oqs_pkg::*;
  logic [15:0] oper_mask_q;
  logic [15:0] oc_map;
  logic [15:0] qc_map;
  logic rd_oe;
  // live inputs placed at their register bit positions
  assign oc_map = {1'b0, oper_cond_in[7], 1'b0, oper_cond_in[6:2], 1'b0,
                   oper_cond_in[1:0], 5'h00};
  assign qc_map = {1'b0, ques_cond_in[6:4], 5'h00, ques_cond_in[3], 2'h0,
                   ques_cond_in[2], 1'b0, ques_cond_in[1:0]};
  assign rd_oe = req_valid && req.cmd == CMD_OPER_EVENT_READ;
  // shadow of the operation mask
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oper_mask_q <= OPER_ENAB_RESET;
    end else if (req_valid && req.cmd == CMD_OPER_ENAB_WRITE) begin
      oper_mask_q <= req.wdata;
    end else if (req_valid && req.cmd == CMD_STATUS_PRESET) begin
      oper_mask_q <= OPER_ENAB_PRESET;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // no condition edge can reach the latch in this span
  sequence s_quiet;
    $stable(oper_cond_in)[*5];
  endsequence
  sequence s_rd_twice;
    rd_oe ##1 (rd_oe && $stable(oper_cond_in));
  endsequence
  a_rsp_one_cycle: assert property (req_valid |=> rsp_valid)
    else $error("no answer after request");
  a_rsp_no_req: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  a_oper_cond_live: assert property ((req_valid &&
    req.cmd == CMD_OPER_COND_READ) |=> rsp_data == $past(oc_map, 3))
    else $error("operation condition read wrong");
  a_ques_cond_live: assert property ((req_valid &&
    req.cmd == CMD_QUES_COND_READ) |=> rsp_data == $past(qc_map, 3))
    else $error("questionable condition read wrong");
  a_oper_ev_bits: assert property (rd_oe |=>
    (rsp_data & ~OPER_LATCH_MASK) == 16'h0000)
    else $error("operation event on unused bit");
  a_ques_ev_bits: assert property ((req_valid &&
    req.cmd == CMD_QUES_EVENT_READ) |=> (rsp_data & 16'hCFFF) == 16'h0000)
    else $error("questionable event on non latching bit");
  a_ev_read_clear: assert property (s_quiet ##0 s_rd_twice |=>
    rsp_data == 16'h0000) else $error("event not cleared by read");
  a_mask_readback: assert property ((req_valid &&
    req.cmd == CMD_OPER_ENAB_READ) |=> rsp_data == $past(oper_mask_q))
    else $error("operation mask read back wrong");
  a_stb_spare_zero: assert property ((status_byte_bits & 8'h77) == 8'h00)
    else $error("status byte spare bit set");
  a_wr_rsp_zero: assert property ((req_valid &&
    (req.cmd == CMD_OPER_ENAB_WRITE || req.cmd == CMD_STATUS_PRESET ||
    req.cmd == CMD_QUES_ENAB_WRITE)) |=> rsp_data == 16'h0000)
    else $error("write or preset answered with data");
  a_oper_cond_unused: assert property ((req_valid &&
    req.cmd == CMD_OPER_COND_READ) |=>
    (rsp_data & ~OPER_USED_MASK) == 16'h0000)
    else $error("operation condition unused bit set");
  a_ques_cond_unused: assert property ((req_valid &&
    req.cmd == CMD_QUES_COND_READ) |=>
    (rsp_data & ~QUES_USED_MASK) == 16'h0000)
    else $error("questionable condition unused bit set");
endmodule // oqs_status_regs_sva

bind oqs_status_regs oqs_status_regs_sva sva_u (.clk_sys(clk_sys),
  .rstn(rstn), .oper_cond_in(oper_cond_in), .ques_cond_in(ques_cond_in),
  .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .status_byte_bits(status_byte_bits));

// *** tb/oqs_status_regs_bench.sv ***
// self-checking bench for the status register block
`timescale 1ns/100ps
module oqs_status_regs_bench;
  import oqs_pkg::*;
  logic clk_sys, rstn, req_valid, rsp_valid;
  oqs_oper_cond_type oc;
  oqs_ques_cond_type qc;
  oqs_req_type req;
  logic [15:0] rsp_data, r;
  logic [7:0] status_byte_bits;
  int fail_count = 0;
  int samples_checked = 0;
  oqs_status_regs dut_u (.clk_sys(clk_sys), .rstn(rstn), .oper_cond_in(oc),
    .ques_cond_in(qc), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .status_byte_bits(status_byte_bits));
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic chk(input string nm, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one command; strobe stays up so calls can run back to back
  task automatic send(input oqs_cmd_type c, input logic [15:0] w);
    req_valid = 1'b1;
    req = '{cmd: c, wdata: w};
    @(posedge clk_sys);
    #1;
    r = rsp_data;
    chk("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
  endtask
  // drop the strobe and let n cycles pass
  task automatic wt(input int n);
    req_valid = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    chk("rsp_idle", {15'h0000, rsp_valid}, 16'h0000);
  endtask
  // mask state straight after reset
  task automatic t_reset;
    send(CMD_OPER_ENAB_READ, 16'h0000);
    chk("mask_rst", r, OPER_ENAB_RESET);
  endtask
  // every defined bit at its place, and only permitted bits latch
  task automatic t_layout;
    oc = '0;
    qc = '0;
    wt(3);
    oc = '1;
    qc = '1;
    wt(5);
    chk("layout_sum", stb(), 16'h0000);
    send(CMD_OPER_COND_READ, 16'h0000);
    chk("oper_layout", r, 16'h5F60);
    send(CMD_QUES_COND_READ, 16'h0000);
    chk("ques_layout", r, 16'h704B);
    send(CMD_OPER_EVENT_READ, 16'h0000);
    chk("oper_ev_all", r, 16'h5F60);
    send(CMD_QUES_EVENT_READ, 16'h0000);
    chk("ques_ev_all", r, 16'h3000);
    send(CMD_OPER_ENAB_WRITE, 16'hFFFF);
    send(CMD_OPER_ENAB_READ, 16'h0000);
    chk("oper_mask_all", r, 16'hFFFF);
    wt(1);
  endtask
  function automatic logic [15:0] stb();
    return {8'h00, status_byte_bits};
  endfunction
  task automatic t_live;
    oc.constant_voltage_mode = 1'b1;
    qc.current_mode_error = 1'b1;
    qc.voltage_mode_error = 1'b1;
    wt(4);
    send(CMD_OPER_COND_READ, 16'h0000);
    chk("oper_cond", r, 16'h0100);
    send(CMD_QUES_COND_READ, 16'h0000);
    chk("ques_cond", r, 16'h0003);
    send(CMD_QUES_EVENT_READ, 16'h0000);
    chk("ques_mode_ev", r, 16'h0000);
    qc = '0;
    wt(3);
    chk("sum_masked", stb(), 16'h0000);
  endtask
  task automatic t_oper;
    send(CMD_OPER_ENAB_WRITE, 16'h0500);
    send(CMD_OPER_ENAB_READ, 16'h0000);
    chk("oper_mask", r, 16'h0500);
    send(CMD_OPER_EVENT_READ, 16'h0000);
    chk("oper_ev", r, 16'h0100);
    send(CMD_OPER_EVENT_READ, 16'h0000);
    chk("oper_ev_clr", r, 16'h0000);
    oc.constant_current_mode = 1'b1;
    wt(6);
    chk("oper_sum", stb(), 16'h0080);
    oc.constant_current_mode = 1'b0;
    wt(6);
    send(CMD_OPER_EVENT_READ, 16'h0000);
    chk("oper_ev_hold", r, 16'h0400);
    wt(3);
    chk("oper_sum_clr", stb(), 16'h0000);
  endtask
  task automatic t_ques;
    send(CMD_QUES_ENAB_WRITE, 16'h3008);
    qc.current_error_flag = 1'b1;
    qc.thermal_error_flag = 1'b1;
    wt(6);
    chk("ques_sum", stb(), 16'h0008);
    send(CMD_QUES_COND_READ, 16'h0000);
    chk("ques_cond_err", r, 16'h2008);
    send(CMD_QUES_EVENT_READ, 16'h0000);
    chk("ques_ev", r, 16'h2000);
    send(CMD_QUES_EVENT_READ, 16'h0000);
    chk("ques_ev_clr", r, 16'h0000);
    qc = '0;
    wt(3);
    chk("ques_sum_clr", stb(), 16'h0000);
  endtask
  task automatic t_preset;
    send(CMD_STATUS_PRESET, 16'h0000);
    chk("preset_rsp", r, 16'h0000);
    send(CMD_OPER_ENAB_READ, 16'h0000);
    chk("preset_oper", r, 16'h2001);
    qc.voltage_error_flag = 1'b1;
    oc.list_running = 1'b1;
    wt(6);
    chk("preset_sum", stb(), 16'h0000);
    send(CMD_QUES_EVENT_READ, 16'h0000);
    chk("ques_ev_volt", r, 16'h1000);
    send(CMD_OPER_EVENT_READ, 16'h0000);
    chk("oper_ev_list", r, 16'h4000);
    wt(1);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    oc = '0;
    qc = '0;
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    wt(2);
    t_reset();
    t_live();
    t_oper();
    t_ques();
    t_preset();
    t_layout();
    end_sim();
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end
endmodule // oqs_status_regs_bench
